// ==== rtl/bsp_boot_map.vh ====
// constants for the boot selection and power mode block
`ifndef BSP_BOOT_MAP_VH
`define BSP_BOOT_MAP_VH
// boot source codes
`define BSP_SRC_STOP 4'h0
`define BSP_SRC_SER1 4'h1
`define BSP_SRC_SER2 4'h2
`define BSP_SRC_FLASH 4'h3
`define BSP_SRC_ABM_FLASH 4'h4
`define BSP_SRC_EXT_MST 4'h5
`define BSP_SRC_ABM_EXT_MST 4'h6
`define BSP_SRC_EXT_PART 4'h7
`define BSP_SRC_ABM_EXT_PART 4'h8
`define BSP_SRC_EMUMEM 4'h9
`define BSP_SRC_SER3 4'hA
`define BSP_SRC_TRISTATE 4'hB
`define BSP_SRC_EMUSPACE 4'hC
// boot rom exit addresses
`define BSP_ADDR_SERIAL 32'hD4000000
`define BSP_ADDR_FLASH 32'hA0000000
`define BSP_ADDR_EXTMEM 32'hA1000000
`define BSP_ADDR_EMUMEM 32'hAFF00000
`define BSP_ADDR_EMUSPACE 32'hDE000000
`define BSP_ADDR_NONE 32'h00000000
// external bus boot configuration word offset
`define BSP_EXT_CFG_OFFSET 32'h00000004
// power modes
`define BSP_MODE_RUN 2'h0
`define BSP_MODE_IDLE 2'h1
`define BSP_MODE_SLEEP 2'h2
// power sequencer states
`define BSP_PS_RUN 3'h0
`define BSP_PS_IDLE 3'h1
`define BSP_PS_DRAIN 3'h2
`define BSP_PS_SUSPEND 3'h3
`define BSP_PS_SLEEP 3'h4
`define BSP_PS_WAKE 3'h5
`endif

// ==== rtl/bsp_boot_decode.v ====
// combinational boot selection decoder
`include "bsp_boot_map.vh"
module bsp_boot_decode (
  input wire breakInputPin,
  input wire [3:0] hardwareConfigPins,
  output reg [3:0] bootSource,
  output reg [31:0] exitAddr,
  output reg extMaster,
  output reg extParticipant,
  output reg crcCheck,
  output reg stopLoop,
  output reg triState
);
  always @* begin
    bootSource = `BSP_SRC_STOP;
    exitAddr = `BSP_ADDR_NONE;
    extMaster = 1'b0;
    extParticipant = 1'b0;
    crcCheck = 1'b0;
    stopLoop = 1'b0;
    triState = 1'b0;
    if (breakInputPin) begin
      case (hardwareConfigPins)
        4'h0: begin
          bootSource = `BSP_SRC_SER1;
          exitAddr = `BSP_ADDR_SERIAL;
        end
        4'h1: begin
          bootSource = `BSP_SRC_SER2;
          exitAddr = `BSP_ADDR_SERIAL;
        end
        4'h2: begin
          bootSource = `BSP_SRC_FLASH;
          exitAddr = `BSP_ADDR_FLASH;
        end
        4'h3: begin
          bootSource = `BSP_SRC_ABM_FLASH;
          crcCheck = 1'b1;
        end
        4'h4: begin
          bootSource = `BSP_SRC_EXT_MST;
          exitAddr = `BSP_ADDR_EXTMEM;
          extMaster = 1'b1;
        end
        4'h5: begin
          bootSource = `BSP_SRC_ABM_EXT_MST;
          extMaster = 1'b1;
          crcCheck = 1'b1;
        end
        4'h6: begin
          bootSource = `BSP_SRC_EXT_PART;
          exitAddr = `BSP_ADDR_EXTMEM;
          extParticipant = 1'b1;
        end
        4'h7: begin
          bootSource = `BSP_SRC_ABM_EXT_PART;
          extParticipant = 1'b1;
          crcCheck = 1'b1;
        end
        4'h8: begin
          bootSource = `BSP_SRC_EMUMEM;
          exitAddr = `BSP_ADDR_EMUMEM;
        end
        4'hF: begin
          bootSource = `BSP_SRC_SER3;
          exitAddr = `BSP_ADDR_SERIAL;
        end
        default: begin
          stopLoop = 1'b1;
        end
      endcase
    end else begin
      case (hardwareConfigPins)
        4'h0: begin
          bootSource = `BSP_SRC_TRISTATE;
          triState = 1'b1;
        end
        4'h8: begin
          bootSource = `BSP_SRC_EMUSPACE;
          exitAddr = `BSP_ADDR_EMUSPACE;
          extMaster = 1'b1;
        end
        default: begin
          stopLoop = 1'b1;
        end
      endcase
    end
  end
endmodule

// ==== rtl/bsp_unit_gate.v ====
// per-unit automatic clock gate with restore on demand
module bsp_unit_gate #(
  parameter IDLE_CYCLES = 8,
  parameter CW = 4
) (
  input wire core_clk,
  input wire rstN,
  input wire unitBusy,
  input wire unitRequest,
  output reg unitClkEn
);
  reg [CW-1:0] idleCnt_r;
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      idleCnt_r <= {CW{1'b0}};
      unitClkEn <= 1'b1;
    end else if (unitBusy || unitRequest) begin
      idleCnt_r <= {CW{1'b0}};
      unitClkEn <= 1'b1;
    end else if (idleCnt_r == IDLE_CYCLES[CW-1:0]) begin
      unitClkEn <= 1'b0;
    end else begin
      idleCnt_r <= idleCnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ==== rtl/bsp_sys_ctrl.v ====
// boot selection latch and run/idle/sleep power sequencer
`include "bsp_boot_map.vh"
module bsp_sys_ctrl #(
  parameter NUM_PERIPH = 8,
  parameter DRAIN_CYCLES = 4,
  parameter AUTO_IDLE_CYCLES = 8
) (
  input wire core_clk,
  input wire arst_n,
  input wire breakInputPin,
  input wire [3:0] hardwareConfigPins,
  input wire [2:0] portZero,
  input wire emuPresent,
  input wire crcDone,
  input wire crcPass,
  input wire [31:0] abmHeaderAddr,
  input wire [1:0] modeRequest,
  input wire modeRequestValid,
  input wire [NUM_PERIPH-1:0] runClkEnCfg,
  input wire [NUM_PERIPH-1:0] idleClkEnCfg,
  input wire [NUM_PERIPH-1:0] sleepClkEnCfg,
  input wire [NUM_PERIPH-1:0] periphIrq,
  input wire [NUM_PERIPH-1:0] irqEnable,
  input wire [NUM_PERIPH-1:0] periphBusy,
  input wire [NUM_PERIPH-1:0] periphAccessReq,
  input wire watchdogEvent,
  input wire nmiPin,
  output reg [3:0] bootSource,
  output reg [31:0] bootExitAddr,
  output reg extMaster,
  output reg extParticipant,
  output reg extChipSelZero,
  output reg emulatorChipSelect,
  output reg [31:0] extCfgAddr,
  output reg bootStopLoop,
  output reg chipTriState,
  output reg bootDone,
  output reg [2:0] softwareOptionField,
  output reg [1:0] powerMode,
  output reg cpuClkEn,
  output wire [NUM_PERIPH-1:0] periphClkEn,
  output reg [NUM_PERIPH-1:0] periphSuspend,
  output reg sleepAck
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg rstSync1_r;
  reg rstN;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1_r <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstN <= rstSync1_r;
    end
  end

  // ------------------------------------------------------------
  // boot selection capture
  // ------------------------------------------------------------
  wire [3:0] decSource;
  wire [31:0] decAddr;
  wire decMaster;
  wire decPart;
  wire decCrc;
  wire decStop;
  wire decTri;
  bsp_boot_decode uDecode (
    .breakInputPin(breakInputPin),
    .hardwareConfigPins(hardwareConfigPins),
    .bootSource(decSource),
    .exitAddr(decAddr),
    .extMaster(decMaster),
    .extParticipant(decPart),
    .crcCheck(decCrc),
    .stopLoop(decStop),
    .triState(decTri)
  );

  // pins are caught by a clocked process after release, never by reset
  reg captured_r;
  reg crcPending_r;
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      captured_r <= 1'b0;
      crcPending_r <= 1'b0;
      bootSource <= `BSP_SRC_STOP;
      bootExitAddr <= `BSP_ADDR_NONE;
      extMaster <= 1'b0;
      extParticipant <= 1'b0;
      extChipSelZero <= 1'b0;
      emulatorChipSelect <= 1'b0;
      extCfgAddr <= `BSP_ADDR_NONE;
      bootStopLoop <= 1'b0;
      chipTriState <= 1'b0;
      bootDone <= 1'b0;
      softwareOptionField <= 3'h0;
    end else if (!captured_r) begin
      captured_r <= 1'b1;
      softwareOptionField <= portZero;
      bootSource <= decSource;
      bootExitAddr <= decAddr;
      extMaster <= decMaster;
      extParticipant <= decPart;
      // chip select zero for external bus boots, emulator space excluded
      extChipSelZero <= (decMaster | decPart) &
        (decSource != `BSP_SRC_EMUSPACE);
      emulatorChipSelect <= (decSource == `BSP_SRC_EMUSPACE);
      extCfgAddr <= ((decMaster | decPart) &
        (decSource != `BSP_SRC_EMUSPACE)) ? `BSP_EXT_CFG_OFFSET :
        `BSP_ADDR_NONE;
      chipTriState <= decTri;
      crcPending_r <= decCrc;
      if (decSource == `BSP_SRC_EMUMEM && !emuPresent) begin
        bootSource <= `BSP_SRC_STOP;
        bootStopLoop <= 1'b1;
        bootExitAddr <= `BSP_ADDR_NONE;
      end else begin
        bootStopLoop <= decStop;
      end
      bootDone <= !decCrc;
    end else if (crcPending_r && crcDone) begin
      // pass takes header address, fail falls to serial
      crcPending_r <= 1'b0;
      bootDone <= 1'b1;
      if (crcPass) begin
        bootExitAddr <= abmHeaderAddr;
      end else begin
        bootExitAddr <= `BSP_ADDR_SERIAL;
        extMaster <= 1'b0;
        extParticipant <= 1'b0;
        extChipSelZero <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // wake detection
  // ------------------------------------------------------------
  reg nmiPrev_r;
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      nmiPrev_r <= 1'b1;
    end else begin
      nmiPrev_r <= nmiPin;
    end
  end
  wire nmiFall = nmiPrev_r & ~nmiPin;
  wire idleWake = watchdogEvent | nmiFall | (|(periphIrq & irqEnable));
  // only running peripherals may wake sleep
  wire sleepWake = watchdogEvent | nmiFall |
    (|(periphIrq & irqEnable & sleepClkEnCfg));

  // ------------------------------------------------------------
  // power sequencer
  // ------------------------------------------------------------
  reg [2:0] psState_r;
  reg [2:0] psState_nxt;
  reg [3:0] drainCnt_r;
  wire drainDone = (drainCnt_r == DRAIN_CYCLES[3:0]);
  wire wantIdle = modeRequestValid && (modeRequest == `BSP_MODE_IDLE);
  wire wantSleep = modeRequestValid && (modeRequest == `BSP_MODE_SLEEP);

  always @* begin
    psState_nxt = psState_r;
    case (psState_r)
      `BSP_PS_RUN: begin
        if (wantIdle) begin
          psState_nxt = `BSP_PS_IDLE;
        end else if (wantSleep) begin
          psState_nxt = `BSP_PS_DRAIN;
        end
      end
      `BSP_PS_IDLE: begin
        if (idleWake) begin
          psState_nxt = `BSP_PS_RUN;
        end
      end
      `BSP_PS_DRAIN: begin
        if (sleepWake) begin
          psState_nxt = `BSP_PS_RUN;
        end else if (drainDone) begin
          psState_nxt = `BSP_PS_SUSPEND;
        end
      end
      `BSP_PS_SUSPEND: begin
        psState_nxt = `BSP_PS_SLEEP;
      end
      `BSP_PS_SLEEP: begin
        if (sleepWake) begin
          psState_nxt = `BSP_PS_WAKE;
        end
      end
      `BSP_PS_WAKE: begin
        psState_nxt = `BSP_PS_RUN;
      end
      default: begin
        psState_nxt = `BSP_PS_RUN;
      end
    endcase
  end

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      psState_r <= `BSP_PS_RUN;
      drainCnt_r <= 4'h0;
    end else begin
      psState_r <= psState_nxt;
      if (psState_r == `BSP_PS_DRAIN) begin
        drainCnt_r <= drainCnt_r + 4'h1;
      end else begin
        drainCnt_r <= 4'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // clock and suspend outputs
  // ------------------------------------------------------------
  reg [NUM_PERIPH-1:0] modeEn;
  always @* begin
    case (psState_r)
      `BSP_PS_IDLE: modeEn = idleClkEnCfg;
      `BSP_PS_SUSPEND,
      `BSP_PS_SLEEP: modeEn = sleepClkEnCfg;
      default: modeEn = runClkEnCfg;
    endcase
  end

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      powerMode <= `BSP_MODE_RUN;
      cpuClkEn <= 1'b1;
      periphSuspend <= {NUM_PERIPH{1'b0}};
      sleepAck <= 1'b0;
    end else begin
      cpuClkEn <= (psState_nxt == `BSP_PS_RUN) ||
        (psState_nxt == `BSP_PS_DRAIN);
      if (psState_nxt == `BSP_PS_IDLE) begin
        powerMode <= `BSP_MODE_IDLE;
      end else if (psState_nxt == `BSP_PS_SLEEP ||
                   psState_nxt == `BSP_PS_SUSPEND) begin
        powerMode <= `BSP_MODE_SLEEP;
      end else begin
        powerMode <= `BSP_MODE_RUN;
      end
      if (psState_nxt == `BSP_PS_SUSPEND ||
          psState_nxt == `BSP_PS_SLEEP) begin
        periphSuspend <= ~sleepClkEnCfg;
      end else begin
        periphSuspend <= {NUM_PERIPH{1'b0}};
      end
      sleepAck <= (psState_nxt == `BSP_PS_SLEEP);
    end
  end

  // a gated unit stays off until busy or addressed, costing one cycle
  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g = g + 1) begin : gUnit
      wire autoEn;
      bsp_unit_gate #(
        .IDLE_CYCLES(AUTO_IDLE_CYCLES),
        .CW(4)
      ) uGate (
        .core_clk(core_clk),
        .rstN(rstN),
        .unitBusy(periphBusy[g]),
        .unitRequest(periphAccessReq[g]),
        .unitClkEn(autoEn)
      );
      assign periphClkEn[g] = modeEn[g] & autoEn & ~periphSuspend[g];
    end
  endgenerate
endmodule

// ==== testbench/bsp_board_model.sv ====
// board side model: strap pins follow sel during hard reset and hold after release
module bsp_board_model (
  input logic arst_n,
  input logic [8:0] sel,
  output logic breakInputPin,
  output logic [3:0] hardwareConfigPins,
  output logic [2:0] portZero,
  output logic emuPresent
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // strap latch
  // ----------------------------------------
  // pins settle only while reset is low
  // a real board cannot move straps later, so neither does this model
  always_latch begin
    if (!arst_n) begin
      {breakInputPin, hardwareConfigPins, portZero, emuPresent} <= sel;
    end
  end
endmodule

// ==== testbench/bsp_sys_ctrl_asserts.sv ====
// concurrent checks on the boot select and power mode block ports
`include "bsp_boot_map.vh"
module bsp_sys_ctrl_chk #(
  parameter NUM_PERIPH = 8,
  parameter DRAIN_CYCLES = 4
) (
  input logic core_clk,
  input logic arst_n,
  input logic [2:0] portZero,
  input logic [1:0] modeRequest,
  input logic modeRequestValid,
  input logic [NUM_PERIPH-1:0] runClkEnCfg,
  input logic [NUM_PERIPH-1:0] sleepClkEnCfg,
  input logic [NUM_PERIPH-1:0] periphIrq,
  input logic [NUM_PERIPH-1:0] irqEnable,
  input logic watchdogEvent,
  input logic nmiPin,
  input logic [3:0] bootSource,
  input logic [31:0] bootExitAddr,
  input logic extChipSelZero,
  input logic [31:0] extCfgAddr,
  input logic bootStopLoop,
  input logic chipTriState,
  input logic bootDone,
  input logic [2:0] softwareOptionField,
  input logic [1:0] powerMode,
  input logic cpuClkEn,
  input logic [NUM_PERIPH-1:0] periphClkEn,
  input logic [NUM_PERIPH-1:0] periphSuspend,
  input logic sleepAck
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence reqIn(logic [1:0] m);
    powerMode == `BSP_MODE_RUN && cpuClkEn && modeRequestValid
      && modeRequest == m;
  endsequence
  sequence sleepSettle;
    powerMode == `BSP_MODE_SLEEP && !cpuClkEn ##1 sleepAck;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  boot_hold_a: assert property (
    bootDone && $past(bootDone) |->
      $stable(bootSource) && $stable(bootExitAddr))
    else $error("boot selection moved after capture");
  stop_decode_a: assert property (
    bootDone |-> bootStopLoop == (bootSource == `BSP_SRC_STOP)
      && chipTriState == (bootSource == `BSP_SRC_TRISTATE))
    else $error("stop loop or tri-state mismatch");
  software_option_field_cap_a: assert property (
    bootDone |-> softwareOptionField == portZero)
    else $error("option field differs from port zero");
  ext_cfg_a: assert property (
    bootDone && (bootSource == `BSP_SRC_EXT_MST
      || bootSource == `BSP_SRC_EXT_PART) |->
      extCfgAddr == `BSP_EXT_CFG_OFFSET && extChipSelZero)
    else $error("external config fetch wrong");
  run_clk_a: assert property (
    powerMode == `BSP_MODE_RUN |-> (periphClkEn & ~runClkEnCfg) == 0)
    else $error("clock on outside run setting");
  idle_entry_a: assert property (
    reqIn(`BSP_MODE_IDLE) |-> ##[1:2]
      (powerMode == `BSP_MODE_IDLE && !cpuClkEn && periphSuspend == 0))
    else $error("idle entry wrong");
  idle_wake_a: assert property (
    powerMode == `BSP_MODE_IDLE
      && (watchdogEvent || (periphIrq & irqEnable) != 0)
      |-> ##[1:2] (powerMode == `BSP_MODE_RUN && cpuClkEn))
    else $error("idle did not wake");
  sleep_gate_a: assert property (
    powerMode == `BSP_MODE_SLEEP |-> !cpuClkEn
      && periphSuspend == ~sleepClkEnCfg
      && (periphClkEn & ~sleepClkEnCfg) == 0)
    else $error("sleep clocking wrong");
  sleep_order_a: assert property (
    reqIn(`BSP_MODE_SLEEP) |->
      (powerMode != `BSP_MODE_SLEEP)[*5] ##[1:3] sleepSettle)
    else $error("sleep entry sequence wrong");
  nmi_wake_a: assert property (
    sleepAck && $fell(nmiPin) |-> ##[1:3] powerMode == `BSP_MODE_RUN)
    else $error("sleep did not wake on nmi");
endmodule
bind bsp_sys_ctrl bsp_sys_ctrl_chk #(
  .NUM_PERIPH(NUM_PERIPH),
  .DRAIN_CYCLES(DRAIN_CYCLES)
) chk_u (.*);

// ==== testbench/test_boot_select_and_power_modes.sv ====
// self-checking bench for the boot select and power mode block
`include "bsp_boot_map.vh"
module test_boot_select_and_power_modes;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [8:0] sel = 9'h000;
  logic crcDone = 1'b0;
  logic crcPass = 1'b0;
  logic [31:0] abmHeaderAddr = 32'h00000000;
  logic [1:0] modeRequest = 2'h0;
  logic modeRequestValid = 1'b0;
  logic watchdogEvent = 1'b0;
  logic nmiPin = 1'b1;
  logic [7:0] runClkEnCfg = 8'hFF;
  logic [7:0] idleClkEnCfg = 8'h7F;
  logic [7:0] sleepClkEnCfg = 8'h0F;
  logic [7:0] periphIrq = 8'h00;
  logic [7:0] irqEnable = 8'hFF;
  logic [7:0] periphBusy = 8'h00;
  logic [7:0] periphAccessReq = 8'h00;
  wire breakInputPin, emuPresent, extMaster, extParticipant;
  wire extChipSelZero, emulatorChipSelect, bootStopLoop, chipTriState;
  wire bootDone, cpuClkEn, sleepAck;
  wire [3:0] hardwareConfigPins, bootSource;
  wire [2:0] portZero, softwareOptionField;
  wire [31:0] bootExitAddr, extCfgAddr;
  wire [1:0] powerMode;
  wire [7:0] periphClkEn, periphSuspend;
  int nFail = 0;
  int cmpCount = 0;
  logic [44:0] rows [12];
  bsp_board_model board_u (.*);
  bsp_sys_ctrl dut_u (.*);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task boot(logic [8:0] s);
    arst_n <= 1'b0;
    sel <= s;
    tick(2);
    chk("bootDone", bootDone, 0);
    chk("cpuClkEn", cpuClkEn, 1);
    arst_n <= 1'b1;
    tick(6);
  endtask
  task req(logic [1:0] m);
    modeRequest <= m;
    modeRequestValid <= 1'b1;
    tick(1);
    modeRequestValid <= 1'b0;
    tick(3);
  endtask
  // zero irq and no watchdog means an nmi falling edge
  task kick(logic [7:0] q, logic wd);
    periphIrq <= q;
    watchdogEvent <= wd;
    nmiPin <= !(q == 0 && !wd);
    tick(1);
    periphIrq <= 8'h00;
    watchdogEvent <= 1'b0;
    nmiPin <= 1'b1;
    tick(4);
  endtask
  function automatic logic [44:0] mk(logic b, logic [3:0] c, logic e,
      logic [3:0] src, logic [31:0] a);
    return {b, c, 3'h5, e, src, a};
  endfunction
  task printVerdict;
    $display("checks %0d errors %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the tests need
  initial begin
    tick(5000);
    nFail++;
    printVerdict;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rows[0] = mk(1, 4'h0, 0, `BSP_SRC_SER1, `BSP_ADDR_SERIAL);
    rows[1] = mk(1, 4'h1, 0, `BSP_SRC_SER2, `BSP_ADDR_SERIAL);
    rows[2] = mk(1, 4'h2, 0, `BSP_SRC_FLASH, `BSP_ADDR_FLASH);
    rows[3] = mk(1, 4'h4, 0, `BSP_SRC_EXT_MST, `BSP_ADDR_EXTMEM);
    rows[4] = mk(1, 4'h6, 0, `BSP_SRC_EXT_PART, `BSP_ADDR_EXTMEM);
    rows[5] = mk(1, 4'h8, 1, `BSP_SRC_EMUMEM, `BSP_ADDR_EMUMEM);
    rows[6] = mk(1, 4'h8, 0, `BSP_SRC_STOP, `BSP_ADDR_NONE);
    rows[7] = mk(1, 4'hF, 0, `BSP_SRC_SER3, `BSP_ADDR_SERIAL);
    rows[8] = mk(1, 4'h9, 0, `BSP_SRC_STOP, `BSP_ADDR_NONE);
    rows[9] = mk(0, 4'h0, 0, `BSP_SRC_TRISTATE, `BSP_ADDR_NONE);
    rows[10] = mk(0, 4'h8, 0, `BSP_SRC_EMUSPACE, `BSP_ADDR_EMUSPACE);
    rows[11] = mk(0, 4'h2, 0, `BSP_SRC_STOP, `BSP_ADDR_NONE);
    foreach (rows[i]) begin
      boot(rows[i][44:36]);
      chk("bootSource", bootSource, rows[i][35:32]);
      // exit address of these two codes is left open
      if (i != 1 && i != 9) begin
        chk("bootExitAddr", bootExitAddr, rows[i][31:0]);
      end
      chk("bootStopLoop", bootStopLoop, i == 6 || i == 8 || i == 11);
      chk("chipTriState", chipTriState, i == 9);
      chk("extMaster", extMaster, i == 3 || i == 10);
      chk("extParticipant", extParticipant, i == 4);
      chk("chipSelZero", extChipSelZero, i == 3 || i == 4);
      chk("emuChipSel", emulatorChipSelect, i == 10);
      chk("extCfgAddr", extCfgAddr, (i == 3 || i == 4) ? 4 : 0);
      chk("swOption", softwareOptionField, 3'h5);
    end
    for (int k = 0; k < 3; k++) begin
      boot({1'b1, 4'(3 + 2 * k), 3'h5, 1'b0});
      chk("bootDone", bootDone, 0);
      crcPass <= (k != 1);
      crcDone <= 1'b1;
      abmHeaderAddr <= 32'hA0000100 + k;
      tick(1);
      crcDone <= 1'b0;
      tick(3);
      chk("bootExitAddr", bootExitAddr,
          k == 1 ? `BSP_ADDR_SERIAL : 32'hA0000100 + k);
      chk("bootDone", bootDone, 1);
      chk("extMaster", extMaster, 0);
      chk("extParticipant", extParticipant, k == 2);
    end
    periphBusy <= 8'hF7;
    boot({1'b1, 4'h2, 3'h5, 1'b0});
    req(`BSP_MODE_IDLE);
    chk("powerMode", powerMode, `BSP_MODE_IDLE);
    chk("cpuClkEn", cpuClkEn, 0);
    chk("periphSuspend", periphSuspend, 0);
    chk("periphClkEn", periphClkEn & 8'hF7, 8'h77);
    req(`BSP_MODE_SLEEP);
    chk("powerMode", powerMode, `BSP_MODE_IDLE);
    kick(8'h00, 1);
    chk("powerMode", powerMode, `BSP_MODE_RUN);
    chk("cpuClkEn", cpuClkEn, 1);
    req(`BSP_MODE_IDLE);
    kick(8'h80, 0);
    chk("powerMode", powerMode, `BSP_MODE_RUN);
    req(`BSP_MODE_SLEEP);
    tick(6);
    chk("powerMode", powerMode, `BSP_MODE_SLEEP);
    chk("sleepAck", sleepAck, 1);
    chk("periphSuspend", periphSuspend, 8'hF0);
    chk("periphClkEn", periphClkEn & 8'hF0, 0);
    chk("periphClkEn", periphClkEn & 8'h07, 8'h07);
    kick(8'h80, 0);
    chk("powerMode", powerMode, `BSP_MODE_SLEEP);
    kick(8'h02, 0);
    chk("powerMode", powerMode, `BSP_MODE_RUN);
    req(`BSP_MODE_SLEEP);
    tick(6);
    kick(8'h00, 0);
    chk("powerMode", powerMode, `BSP_MODE_RUN);
    tick(12);
    chk("periphClkEn", periphClkEn & 8'h08, 0);
    periphAccessReq <= 8'h08;
    periphBusy <= 8'h08;
    tick(2);
    periphAccessReq <= 8'h00;
    chk("periphClkEn", periphClkEn & 8'h08, 8'h08);
    tick(12);
    chk("periphClkEn", periphClkEn & 8'h08, 8'h08);
    printVerdict;
  end
endmodule
